// File: hw/blrs_consts.svh
// constants of the boot-load record source: addresses, codes, field positions, timing
// assumes inclusion by bare name from every design file that needs them
`ifndef BLRS_CONSTS_SVH
`define BLRS_CONSTS_SVH

`define BLRS_RT_ADDR 5'h1F
`define BLRS_SA_LOAD 5'h01
`define BLRS_SA_MODE_LO 5'h00
`define BLRS_SA_MODE_HI 5'h1F
`define BLRS_MC_STATUS 5'h02
`define BLRS_MC_INIT_DEV 5'h14
`define BLRS_MC_INIT_IO 5'h15

`define BLRS_CMD_ADDR_LSB 11
`define BLRS_CMD_TR_BIT 10
`define BLRS_CMD_SA_LSB 5

`define BLRS_ST_ME_BIT 10
`define BLRS_ST_BY_BIT 9
`define BLRS_ST_DR_BIT 8
`define BLRS_ST_TF_BIT 0

`define BLRS_HDR_WORDS 6'h04
`define BLRS_TRL_WORDS 6'h02
`define BLRS_MSG_MAX_WORDS 6'h20
`define BLRS_COUNT_ZERO_WORDS 13'h1000
`define BLRS_LOAD_ADDR_BITS 16
`define BLRS_PAGE_BITS 13

`define BLRS_CLK_PERIOD_NS 25
`define BLRS_RESP_MIN_NS 2000
`define BLRS_RESP_MAX_NS 5000
`define BLRS_RESP_CYC ((`BLRS_RESP_MIN_NS + `BLRS_CLK_PERIOD_NS - 1) / `BLRS_CLK_PERIOD_NS)

`endif

// File: hw/blrs_pkg.sv
// types of the boot-load record source: transfer modes, phases, message kinds
// assumes nothing of its surroundings
package blrs_pkg;

	// transfer mode field encoding of header word 1
	typedef enum logic [1:0] {
		MODE_NONE = 2'h0,
		MODE_UNUSED = 2'h1,
		MODE_16 = 2'h2,
		MODE_32 = 2'h3
	} transfer_mode_t;

	// position in the record sequence
	typedef enum logic [2:0] {
		PH_WAIT_INIT,
		PH_WAIT_HDR,
		PH_DATA,
		PH_TRAILER,
		PH_DONE
	} phase_t;

	// transmitter sequencing
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_DELAY,
		TX_SEND
	} tx_state_t;

	// what follows the status word
	typedef enum logic [1:0] {
		K_NONE,
		K_HDR,
		K_DATA,
		K_TRL
	} msg_kind_t;

endpackage : blrs_pkg

// File: hw/blrs_stream_if.sv
// valid/ready word stream between the record source's own modules
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none

interface blrs_stream_if #(
	parameter int W = 32
);
	logic [W-1:0] data; // word carried
	logic valid; // data is offered
	logic ready; // sink takes it this cycle

	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : blrs_stream_if

`default_nettype wire

// File: hw/blrs_buf2.sv
// two-entry buffer in the load data path; head word comes from a register
// assumes producer and consumer on the same clock
`timescale 1ns/1ps
`default_nettype none

module blrs_buf2 (
	input wire logic clk,
	input wire logic reset_n,
	blrs_stream_if.snk in_s,
	blrs_stream_if.src out_s
);
	logic [$bits(in_s.data)-1:0] d0_r, d0_nxt; // head entry
	logic [$bits(in_s.data)-1:0] d1_r, d1_nxt; // second entry
	logic [1:0] cnt_r, cnt_nxt; // occupancy 0..2
	logic push;
	logic pop;

	// full at two entries, so a stalled reader pushes back on the writer
	assign in_s.ready = (cnt_r != 2'h2);
	assign out_s.valid = (cnt_r != 2'h0);
	assign out_s.data = d0_r;
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	// next contents
	always_comb begin
		d0_nxt = d0_r;
		d1_nxt = d1_r;
		cnt_nxt = cnt_r;
		if (push && pop) begin
			// through traffic: shift, then refill
			if (cnt_r == 2'h1) begin
				d0_nxt = in_s.data;
			end else begin
				d0_nxt = d1_r;
				d1_nxt = in_s.data;
			end
		end else if (pop) begin
			d0_nxt = d1_r;
			cnt_nxt = cnt_r - 2'h1;
		end else if (push) begin
			if (cnt_r == 2'h0) begin
				d0_nxt = in_s.data;
			end else begin
				d1_nxt = in_s.data;
			end
			cnt_nxt = cnt_r + 2'h1;
		end
	end

	// registers only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			d0_r <= '0;
			d1_r <= '0;
			cnt_r <= 2'h0;
		end else begin
			d0_r <= d0_nxt;
			d1_r <= d1_nxt;
			cnt_r <= cnt_nxt;
		end
	end

endmodule : blrs_buf2

`default_nettype wire

// File: hw/blrs_resp_delay.sv
// one-shot counter: done pulses CYC cycles after start
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none

module blrs_resp_delay #(
	parameter int CYC = 80
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	output logic done
);
	localparam int W = $clog2(CYC + 1);
	logic [W-1:0] cnt_r, cnt_nxt; // cycles still to wait

	// done while the last cycle of the wait runs
	assign done = (cnt_r == W'(1));

	// next count; a fresh start restarts the wait
	always_comb begin
		cnt_nxt = cnt_r;
		if (start) begin
			cnt_nxt = W'(CYC);
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - W'(1);
		end
	end

	// register only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule : blrs_resp_delay

`default_nettype wire

// File: hw/blrs_top.sv
// boot-load record source: remote-terminal end answering a bus controller
// assumes a word-level bus decoder/encoder on CLK (40 MHz) and a record source feeding header and data
`timescale 1ns/1ps
`default_nettype none
`include "blrs_consts.svh"

module blrs_top #(
	parameter int LOAD_ADDR_BITS = `BLRS_LOAD_ADDR_BITS,
	parameter int PAGE_BITS = `BLRS_PAGE_BITS
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CMD_VALID,
	input wire logic [15:0] CMD_WORD,
	output logic [15:0] TX_WORD,
	output logic TX_IS_STATUS,
	output logic TX_VALID,
	input wire logic TX_READY,
	input wire logic HDR_VALID,
	input wire logic [1:0] HDR_TRANSFER_MODE,
	input wire logic [11:0] HDR_COUNT,
	input wire logic [15:0] HDR_LOAD_ADDR,
	input wire logic [15:0] HDR_ENTRY_ADDR,
	input wire logic [12:0] HDR_PAGE,
	input wire logic HDR_TRANSFER_CONTROL,
	input wire logic [5:0] TRL_PAGE_CNT,
	input wire logic [5:0] TRL_FIRST_PAGE,
	output logic HDR_TAKEN,
	input wire logic [31:0] DATA_IN,
	input wire logic DATA_IN_VALID,
	output logic DATA_IN_READY,
	input wire logic NOT_YET_PREPARED,
	input wire logic TERMINAL_FAULT,
	output logic DATA_AVAILABLE_FLAG,
	output logic BAD_TRANSFER_FLAG,
	output logic LOAD_DONE
);
	// response gap, rounded up to whole cycles
	localparam int RESP_CYC = `BLRS_RESP_CYC;
	// masks keep unused address and page bits at zero
	localparam logic [15:0] ADDR_MASK = 16'((32'h1 << LOAD_ADDR_BITS) - 32'h1);
	localparam logic [12:0] PAGE_MASK = 13'((32'h1 << PAGE_BITS) - 32'h1);

	blrs_stream_if #(.W(32)) in_s (); // record source into buffer
	blrs_stream_if #(.W(32)) out_s (); // buffer into transmitter

	blrs_pkg::phase_t phase_r, phase_nxt; // record sequence position
	blrs_pkg::tx_state_t tx_r, tx_nxt; // transmitter state
	blrs_pkg::msg_kind_t kind_r, kind_nxt; // words after the status word
	logic [15:0] word_r, word_nxt; // word offered to encoder
	logic full_r, full_nxt; // word_r holds an unsent word
	logic stat_r, stat_nxt; // word_r is a status word
	logic [5:0] left_r, left_nxt; // data words still to load
	logic [1:0] idx_r, idx_nxt; // word index inside header/trailer
	logic half_r, half_nxt; // next 32-bit word half is the high one
	logic [15:0] sum_r, sum_nxt; // running checksum
	logic [12:0] rem_r, rem_nxt; // data words left in the record
	logic [1:0] mode_r, mode_nxt; // transfer mode of current header
	logic tc_r, tc_nxt; // transfer_control of current header
	logic me_r, me_nxt; // bad_transfer_flag for the current message
	logic dr_r, dr_nxt; // registered data_available_flag
	logic taken_r, taken_nxt; // header handed over pulse
	logic [1:0] s1_r, s2_r, s3_r; // pin synchroniser stages
	logic [1:0] pins_r, pins_nxt; // filtered {fault, not prepared}

	logic dly_start; // command accepted, start reply gap
	logic dly_done; // reply gap over
	logic hdr_ok; // header on the inputs may be sent
	logic dr_now; // data available for the next load message
	logic src_ok; // next data word can be loaded
	logic take; // encoder takes word_r
	logic load; // load a data word into word_r
	logic [15:0] dword; // next data word
	logic [4:0] cmd_sa;
	logic [4:0] cmd_wc;
	logic cmd_mine;

	blrs_resp_delay #(.CYC(RESP_CYC)) u_delay (
		.clk(CLK),
		.reset_n(RESET_N),
		.start(dly_start),
		.done(dly_done)
	);

	blrs_buf2 u_buf (
		.clk(CLK),
		.reset_n(RESET_N),
		.in_s(in_s),
		.out_s(out_s)
	);

	// source side of the buffer; its ready stalls the record source
	assign in_s.data = DATA_IN;
	assign in_s.valid = DATA_IN_VALID;
	assign DATA_IN_READY = in_s.ready;

	// pin inputs: three stages, a change counts when stages two and three agree
	always_comb begin
		pins_nxt = pins_r;
		if (s2_r[0] == s3_r[0]) begin
			pins_nxt[0] = s3_r[0];
		end
		if (s2_r[1] == s3_r[1]) begin
			pins_nxt[1] = s3_r[1];
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s1_r <= 2'h0;
			s2_r <= 2'h0;
			s3_r <= 2'h0;
			pins_r <= 2'h0;
		end else begin
			s1_r <= {TERMINAL_FAULT, NOT_YET_PREPARED};
			s2_r <= s1_r;
			s3_r <= s2_r;
			pins_r <= pins_nxt;
		end
	end

	// command fields
	assign cmd_sa = CMD_WORD[`BLRS_CMD_SA_LSB +: 5];
	assign cmd_wc = CMD_WORD[4:0];
	// answer only our own address; a command while replying is dropped
	assign cmd_mine = CMD_VALID && (CMD_WORD[`BLRS_CMD_ADDR_LSB +: 5] == `BLRS_RT_ADDR)
		&& (tx_r == blrs_pkg::TX_IDLE);
	assign dly_start = cmd_mine;

	// mode 01 would halt the receiver, so such a header is never offered
	assign hdr_ok = HDR_VALID && (HDR_TRANSFER_MODE != blrs_pkg::MODE_UNUSED);

	// data availability seen by the next status reply
	always_comb begin
		case (phase_r)
			blrs_pkg::PH_WAIT_HDR: dr_now = hdr_ok;
			// polls only look; the buffered word waits for a load command
			blrs_pkg::PH_DATA: dr_now = out_s.valid && (rem_r != 13'h0000);
			blrs_pkg::PH_TRAILER: dr_now = 1'b1;
			default: dr_now = 1'b0;
		endcase
	end

	// next data word for the message in progress
	always_comb begin
		dword = 16'h0000;
		case (kind_r)
			blrs_pkg::K_HDR: begin
				case (idx_r)
					2'h0: dword = {HDR_TRANSFER_MODE, 2'b00, HDR_COUNT};
					2'h1: dword = HDR_LOAD_ADDR & ADDR_MASK;
					// entry address has meaning only with no transfer
					2'h2: dword = (HDR_TRANSFER_MODE == blrs_pkg::MODE_NONE) ?
						(HDR_ENTRY_ADDR & ADDR_MASK) : 16'h0000;
					default: dword = {HDR_PAGE & PAGE_MASK, 2'b00, HDR_TRANSFER_CONTROL};
				endcase
			end
			blrs_pkg::K_DATA: begin
				// 32-bit values: low half first, high half second
				dword = ((mode_r == blrs_pkg::MODE_32) && half_r) ?
					out_s.data[31:16] : out_s.data[15:0];
			end
			blrs_pkg::K_TRL: begin
				dword = (idx_r == 2'h0) ?
					{2'b00, TRL_PAGE_CNT, 2'b00, TRL_FIRST_PAGE} : sum_r;
			end
			default: dword = 16'h0000;
		endcase
	end

	// only memory data can run dry; header and trailer come from held inputs
	assign src_ok = (kind_r != blrs_pkg::K_DATA) || out_s.valid;
	assign take = full_r && TX_READY;
	assign load = (tx_r == blrs_pkg::TX_SEND) && (!full_r || take) && (left_r != 6'h00) && src_ok;
	// a buffer entry leaves after its last half is loaded
	assign out_s.ready = load && (kind_r == blrs_pkg::K_DATA)
		&& ((mode_r != blrs_pkg::MODE_32) || half_r);

	// transmitter and record sequencing
	always_comb begin
		phase_nxt = phase_r;
		tx_nxt = tx_r;
		kind_nxt = kind_r;
		word_nxt = word_r;
		full_nxt = full_r;
		stat_nxt = stat_r;
		left_nxt = left_r;
		idx_nxt = idx_r;
		half_nxt = half_r;
		sum_nxt = sum_r;
		rem_nxt = rem_r;
		mode_nxt = mode_r;
		tc_nxt = tc_r;
		me_nxt = me_r;
		taken_nxt = 1'b0;
		dr_nxt = dr_now;
		case (tx_r)
			blrs_pkg::TX_IDLE: begin
				if (cmd_mine) begin
					tx_nxt = blrs_pkg::TX_DELAY;
					kind_nxt = blrs_pkg::K_NONE;
					left_nxt = 6'h00;
					me_nxt = 1'b0; // cleared for each message without error
					if ((cmd_sa == `BLRS_SA_MODE_LO) || (cmd_sa == `BLRS_SA_MODE_HI)) begin
						// mode codes answer with status only
						if (cmd_wc == `BLRS_MC_INIT_IO) begin
							if (phase_r == blrs_pkg::PH_WAIT_INIT) begin
								phase_nxt = blrs_pkg::PH_WAIT_HDR;
							end
						end else if ((cmd_wc != `BLRS_MC_STATUS) && (cmd_wc != `BLRS_MC_INIT_DEV)) begin
							me_nxt = 1'b1; // undefined mode code
						end
					end else if ((cmd_sa == `BLRS_SA_LOAD) && CMD_WORD[`BLRS_CMD_TR_BIT]) begin
						case (phase_r)
							blrs_pkg::PH_WAIT_HDR: begin
								if (hdr_ok) begin
									kind_nxt = blrs_pkg::K_HDR;
									left_nxt = `BLRS_HDR_WORDS;
								end else begin
									me_nxt = 1'b1;
								end
							end
							blrs_pkg::PH_DATA: begin
								// word count zero stands for a full group
								kind_nxt = blrs_pkg::K_DATA;
								left_nxt = (cmd_wc == 5'h00) ? `BLRS_MSG_MAX_WORDS : {1'b0, cmd_wc};
							end
							blrs_pkg::PH_TRAILER: begin
								kind_nxt = blrs_pkg::K_TRL;
								left_nxt = `BLRS_TRL_WORDS;
							end
							default: me_nxt = 1'b1; // load command out of sequence
						endcase
					end else begin
						me_nxt = 1'b1; // unknown subaddress or direction
					end
				end
			end
			blrs_pkg::TX_DELAY: begin
				// reply gap over: status word first
				if (dly_done) begin
					tx_nxt = blrs_pkg::TX_SEND;
					word_nxt = 16'h0000;
					word_nxt[15 -: 5] = `BLRS_RT_ADDR;
					word_nxt[`BLRS_ST_ME_BIT] = me_r;
					word_nxt[`BLRS_ST_BY_BIT] = pins_r[0];
					word_nxt[`BLRS_ST_DR_BIT] = dr_now;
					word_nxt[`BLRS_ST_TF_BIT] = pins_r[1];
					full_nxt = 1'b1;
					stat_nxt = 1'b1;
					idx_nxt = 2'h0;
					half_nxt = 1'b0;
					if (kind_r == blrs_pkg::K_HDR) begin
						// a new transaction starts the checksum afresh
						sum_nxt = 16'h0000;
						mode_nxt = HDR_TRANSFER_MODE;
						tc_nxt = HDR_TRANSFER_CONTROL;
						rem_nxt = (HDR_COUNT == 12'h000) ? `BLRS_COUNT_ZERO_WORDS : {1'b0, HDR_COUNT};
					end
				end
			end
			blrs_pkg::TX_SEND: begin
				if (load) begin
					word_nxt = dword;
					full_nxt = 1'b1;
					stat_nxt = 1'b0;
					left_nxt = left_r - 6'h01;
					idx_nxt = idx_r + 2'h1;
					// every data word but the checksum itself, carries dropped
					if (!((kind_r == blrs_pkg::K_TRL) && (idx_r == 2'h1))) begin
						sum_nxt = sum_r + dword;
					end
					if (kind_r == blrs_pkg::K_DATA) begin
						half_nxt = (mode_r == blrs_pkg::MODE_32) && !half_r;
						if (rem_r != 13'h0000) begin
							rem_nxt = rem_r - 13'h0001;
						end
					end
				end else if (take) begin
					full_nxt = 1'b0;
				end
				// message over once the last word has been taken
				if (!full_r && (left_r == 6'h00)) begin
					tx_nxt = blrs_pkg::TX_IDLE;
					case (kind_r)
						blrs_pkg::K_HDR: begin
							taken_nxt = 1'b1;
							phase_nxt = (mode_r == blrs_pkg::MODE_NONE) ?
								blrs_pkg::PH_TRAILER : blrs_pkg::PH_DATA;
						end
						blrs_pkg::K_DATA: begin
							if (rem_r == 13'h0000) begin
								phase_nxt = blrs_pkg::PH_TRAILER;
							end
						end
						blrs_pkg::K_TRL: begin
							// more records follow while transfer_control is set
							phase_nxt = tc_r ? blrs_pkg::PH_WAIT_INIT : blrs_pkg::PH_DONE;
						end
						default: phase_nxt = phase_r;
					endcase
				end
			end
			default: tx_nxt = blrs_pkg::TX_IDLE;
		endcase
	end

	// registers only
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			phase_r <= blrs_pkg::PH_WAIT_INIT;
			tx_r <= blrs_pkg::TX_IDLE;
			kind_r <= blrs_pkg::K_NONE;
			word_r <= 16'h0000;
			full_r <= 1'b0;
			stat_r <= 1'b0;
			left_r <= 6'h00;
			idx_r <= 2'h0;
			half_r <= 1'b0;
			sum_r <= 16'h0000;
			rem_r <= 13'h0000;
			mode_r <= 2'h0;
			tc_r <= 1'b0;
			me_r <= 1'b0;
			dr_r <= 1'b0;
			taken_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			tx_r <= tx_nxt;
			kind_r <= kind_nxt;
			word_r <= word_nxt;
			full_r <= full_nxt;
			stat_r <= stat_nxt;
			left_r <= left_nxt;
			idx_r <= idx_nxt;
			half_r <= half_nxt;
			sum_r <= sum_nxt;
			rem_r <= rem_nxt;
			mode_r <= mode_nxt;
			tc_r <= tc_nxt;
			me_r <= me_nxt;
			dr_r <= dr_nxt;
			taken_r <= taken_nxt;
		end
	end

	// outputs
	assign TX_WORD = word_r;
	assign TX_IS_STATUS = stat_r;
	assign TX_VALID = full_r;
	assign HDR_TAKEN = taken_r;
	assign DATA_AVAILABLE_FLAG = dr_r;
	assign BAD_TRANSFER_FLAG = me_r;
	assign LOAD_DONE = (phase_r == blrs_pkg::PH_DONE);

endmodule : blrs_top

`default_nettype wire

// File: dv/blrs_top_assertions.sv
// checker on the record source ports: status framing, reply timing, header words
// assumes a bind into blrs_top and one clock domain
`timescale 1ns/1ps
`default_nettype none

module blrs_top_assertions #(
	parameter int LOAD_ADDR_BITS = 16,
	parameter int PAGE_BITS = 13
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CMD_VALID,
	input wire logic [15:0] TX_WORD,
	input wire logic TX_IS_STATUS,
	input wire logic TX_VALID,
	input wire logic TX_READY,
	input wire logic [1:0] HDR_TRANSFER_MODE,
	input wire logic [11:0] HDR_COUNT,
	input wire logic [15:0] HDR_LOAD_ADDR,
	input wire logic [15:0] HDR_ENTRY_ADDR,
	input wire logic [12:0] HDR_PAGE,
	input wire logic HDR_TRANSFER_CONTROL,
	input wire logic HDR_TAKEN,
	input wire logic LOAD_DONE
);
	localparam logic [15:0] AMASK = 16'hFFFF >> (16 - LOAD_ADDR_BITS); // address bits kept
	localparam logic [12:0] PMASK = 13'h1FFF >> (13 - PAGE_BITS); // page bits kept
	logic take; // encoder takes a word
	logic [2:0] wi_r; // data words since the last status word, stops at 4
	logic [15:0] hw_r [4]; // first four data words of the latest reply

	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	assign take = TX_VALID && TX_READY;

	// keep the head of each reply; header fields are judged once the header is reported taken
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wi_r <= 3'h0;
		end else if (take && TX_IS_STATUS) begin
			wi_r <= 3'h0;
		end else if (take && wi_r < 3'h4) begin
			hw_r[wi_r[1:0]] <= TX_WORD;
			wi_r <= wi_r + 3'h1;
		end
	end

	a_status_fixed_bits: assert property (TX_VALID && TX_IS_STATUS |-> TX_WORD[15:11] == 5'h1F && TX_WORD[7:1] == 7'h00)
		else $error("status word address or spare bits wrong");
	a_reply_gap_exact: assert property ($rose(TX_VALID) && TX_IS_STATUS |-> $past(CMD_VALID, 81))
		else $error("status reply not 81 cycles after its command");
	a_word_holds: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_WORD) && $stable(TX_IS_STATUS))
		else $error("offered word changed before it was taken");
	a_taken_after_four: assert property (HDR_TAKEN |-> wi_r == 3'h4 && $past(take, 2) && !$past(TX_VALID))
		else $error("header reported taken at the wrong moment");
	a_taken_one_shot: assert property (HDR_TAKEN |=> !HDR_TAKEN [*8])
		else $error("header taken pulse repeated");
	a_hdr_mode_count: assert property (HDR_TAKEN |-> hw_r[0] == {$past(HDR_TRANSFER_MODE), 2'h0, $past(HDR_COUNT)})
		else $error("header word 1 wrong");
	a_hdr_addresses: assert property (HDR_TAKEN |-> hw_r[1] == ($past(HDR_LOAD_ADDR) & AMASK) &&
		hw_r[2] == (($past(HDR_TRANSFER_MODE) == 2'h0) ? ($past(HDR_ENTRY_ADDR) & AMASK) : 16'h0000))
		else $error("header word 2 or 3 wrong");
	a_hdr_page_word: assert property (HDR_TAKEN |-> hw_r[3] == {$past(HDR_PAGE) & PMASK, 2'h0, $past(HDR_TRANSFER_CONTROL)})
		else $error("header word 4 wrong");

	c_header: cover property (HDR_TAKEN);
	c_stall: cover property (TX_VALID && !TX_READY);
	c_done: cover property ($rose(LOAD_DONE));
endmodule : blrs_top_assertions

bind blrs_top blrs_top_assertions #(.LOAD_ADDR_BITS(LOAD_ADDR_BITS), .PAGE_BITS(PAGE_BITS)) i_chk (
	.CLK(CLK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID), .TX_WORD(TX_WORD), .TX_IS_STATUS(TX_IS_STATUS),
	.TX_VALID(TX_VALID), .TX_READY(TX_READY), .HDR_TRANSFER_MODE(HDR_TRANSFER_MODE), .HDR_COUNT(HDR_COUNT),
	.HDR_LOAD_ADDR(HDR_LOAD_ADDR), .HDR_ENTRY_ADDR(HDR_ENTRY_ADDR), .HDR_PAGE(HDR_PAGE),
	.HDR_TRANSFER_CONTROL(HDR_TRANSFER_CONTROL), .HDR_TAKEN(HDR_TAKEN), .LOAD_DONE(LOAD_DONE)
);

`default_nettype wire

// File: dv/blrs_bc_model.sv
// bus controller stand-in: sends command words, collects the terminal's reply words
// assumes xact is called from one process, between rising edges
`timescale 1ns/1ps
`default_nettype none

module blrs_bc_model (
	input wire logic clk,
	input wire logic slow,
	output logic cmd_valid,
	output logic [15:0] cmd_word,
	input wire logic [15:0] tx_word,
	input wire logic tx_is_status,
	input wire logic tx_valid,
	output logic tx_ready
);
	logic [16:0] rx[$]; // every word taken, status mark in bit 16
	int base; // index of the first word of the latest reply
	int got; // words seen in the latest reply

	initial begin
		cmd_valid = 1'b0;
		cmd_word = 16'h0000;
		tx_ready = 1'b1;
	end

	// slow mode stalls the encoder every other cycle
	always @(negedge clk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end

	// take a word on each valid and ready edge
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			rx.push_back({tx_is_status, tx_word});
		end
	end

	// one command, then wait for the status and n data words; a silent terminal ends it after 400 cycles
	task automatic xact(input logic [15:0] cmd, input int n);
		int t;
		base = rx.size();
		@(negedge clk);
		cmd_word <= cmd;
		cmd_valid <= 1'b1;
		@(negedge clk);
		cmd_valid <= 1'b0;
		cmd_word <= ~cmd; // a released line does not keep its last value
		t = 0;
		while (rx.size() < base + n + 1 && t < 400) begin
			@(negedge clk);
			t++;
		end
		got = rx.size() - base;
		repeat (4) @(negedge clk); // gap before the next command
	endtask : xact
endmodule : blrs_bc_model

`default_nettype wire

// File: dv/blrs_top_tb.sv
// bench of the boot-load record source: polls, header, data and trailer replies
// assumes design, checker and controller stand-in compiled first
`timescale 1ns/1ps
`default_nettype none

module blrs_top_tb;
	logic clk, reset_n, slow, cmd_valid, tx_is_status, tx_valid, tx_ready; // clock and controller side
	logic [15:0] cmd_word, tx_word, ld, ent, sum; // bus words, header addresses, expected sum
	logic hv, tc, taken, dv, drdy, nyp, tf, avail, bad, done; // handshakes and flags
	logic [1:0] mode; // header transfer mode
	logic [11:0] cnt; // header word count
	logic [12:0] page; // header page number
	logic [5:0] pcnt, pfirst; // trailer page register fields
	logic [31:0] din; // record data value
	int errors, total_checks, cycles; // mismatches, comparisons, elapsed clocks

	blrs_top i_dut (.CLK(clk), .RESET_N(reset_n), .CMD_VALID(cmd_valid), .CMD_WORD(cmd_word),
		.TX_WORD(tx_word), .TX_IS_STATUS(tx_is_status), .TX_VALID(tx_valid), .TX_READY(tx_ready),
		.HDR_VALID(hv), .HDR_TRANSFER_MODE(mode), .HDR_COUNT(cnt), .HDR_LOAD_ADDR(ld), .HDR_ENTRY_ADDR(ent),
		.HDR_PAGE(page), .HDR_TRANSFER_CONTROL(tc), .TRL_PAGE_CNT(pcnt), .TRL_FIRST_PAGE(pfirst),
		.HDR_TAKEN(taken), .DATA_IN(din), .DATA_IN_VALID(dv), .DATA_IN_READY(drdy), .NOT_YET_PREPARED(nyp),
		.TERMINAL_FAULT(tf), .DATA_AVAILABLE_FLAG(avail), .BAD_TRANSFER_FLAG(bad), .LOAD_DONE(done));
	blrs_bc_model i_bc (.clk(clk), .slow(slow), .cmd_valid(cmd_valid), .cmd_word(cmd_word), .tx_word(tx_word),
		.tx_is_status(tx_is_status), .tx_valid(tx_valid), .tx_ready(tx_ready));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// a hang is cut short well above the few thousand cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one command and its status word; the ready bit is only defined in poll replies
	task automatic stat(input logic [15:0] cmd, input logic [15:0] st, input int n);
		logic [15:0] m;
		m = (cmd == 16'hFC02) ? 16'hFFFF : 16'hFEFF;
		i_bc.xact(cmd, n);
		chk("reply length", 16'(n + 1), 16'(i_bc.got));
		chk("status mark", 16'h0001, 16'(i_bc.rx[i_bc.base][16]));
		chk("status word", st & m, i_bc.rx[i_bc.base][15:0] & m);
	endtask : stat

	// a reply with data words; each expected word also joins the expected sum
	task automatic xact(input logic [15:0] cmd, input logic [15:0] st, input logic [15:0] w[$]);
		stat(cmd, st, w.size());
		foreach (w[j]) begin
			chk("data word", w[j], i_bc.rx[i_bc.base + j + 1][15:0]);
			sum = sum + w[j];
		end
	endtask : xact

	// offer one record value and hold it until the buffer takes it
	task automatic push(input logic [31:0] d);
		@(negedge clk);
		din = d;
		dv = 1'b1;
		while (drdy !== 1'b1) @(negedge clk);
		@(negedge clk);
		dv = 1'b0;
		din = ~d;
	endtask : push

	initial begin
		errors = 0;
		total_checks = 0;
		cycles = 0;
		sum = 16'h0000;
		reset_n = 1'b0;
		slow = 1'b0;
		hv = 1'b0;
		mode = 2'h1;
		cnt = 12'h004;
		ld = 16'h1234;
		ent = 16'hBEEF;
		page = 13'h0ABC;
		tc = 1'b1;
		pcnt = 6'h05;
		pfirst = 6'h03;
		din = 32'h00000000;
		dv = 1'b0;
		nyp = 1'b1;
		tf = 1'b1;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (6) @(negedge clk);
		// busy and fault pins, a foreign address, then a header mode that must never go out
		stat(16'hFC02, 16'hFA01, 0);
		nyp = 1'b0;
		tf = 1'b0;
		hv = 1'b1;
		i_bc.xact(16'h0C02, 0);
		chk("foreign reply", 16'h0000, 16'(i_bc.got));
		stat(16'hFC15, 16'hF800, 0);
		stat(16'hFC02, 16'hF800, 0);
		chk("ready flag", 16'h0000, 16'(avail));
		stat(16'hFC24, 16'hFC00, 0);
		chk("error flag", 16'h0001, 16'(bad));
		hv = 1'b0;
		$display("test bad_mode done");
		// 32-bit mode, wrong subaddress, full buffer, stalled encoder, trailer with sum
		@(negedge clk);
		mode = 2'h3;
		hv = 1'b1;
		stat(16'hFC02, 16'hF900, 0);
		chk("ready flag", 16'h0001, 16'(avail));
		stat(16'hFC44, 16'hFC00, 0);
		stat(16'hF824, 16'hFC00, 0);
		chk("error flag", 16'h0001, 16'(bad));
		sum = 16'h0000;
		xact(16'hFC24, 16'hF800, {16'hC004, 16'h1234, 16'h0000, 16'h55E1});
		chk("error flag", 16'h0000, 16'(bad));
		push(32'h22221111);
		push(32'h44443333);
		chk("ready when full", 16'h0000, 16'(drdy));
		stat(16'hFC02, 16'hF900, 0);
		stat(16'hFC02, 16'hF900, 0);
		slow = 1'b1;
		xact(16'hFC24, 16'hF900, {16'h1111, 16'h2222, 16'h3333, 16'h4444});
		slow = 1'b0;
		chk("ready when empty", 16'h0001, 16'(drdy));
		stat(16'hFC02, 16'hF900, 0);
		xact(16'hFC22, 16'hF900, {16'h0503, sum + 16'h0503});
		stat(16'hFC02, 16'hF800, 0);
		chk("load done", 16'h0000, 16'(done));
		hv = 1'b0;
		$display("test data_load done");
		// 16-bit mode: one word from the low half only, then the trailer
		@(negedge clk);
		mode = 2'h2;
		cnt = 12'h001;
		hv = 1'b1;
		stat(16'hFC15, 16'hF800, 0);
		stat(16'hFC02, 16'hF900, 0);
		sum = 16'h0000;
		xact(16'hFC24, 16'hF800, {16'h8001, 16'h1234, 16'h0000, 16'h55E1});
		push(32'hABCD5678);
		stat(16'hFC02, 16'hF900, 0);
		xact(16'hFC21, 16'hF900, {16'h5678});
		stat(16'hFC02, 16'hF900, 0);
		xact(16'hFC22, 16'hF900, {16'h0503, sum + 16'h0503});
		hv = 1'b0;
		$display("test mode16 done");
		// no-transfer header goes straight to the trailer and ends the load
		@(negedge clk);
		mode = 2'h0;
		cnt = 12'hFFF;
		ent = 16'h0ABC;
		page = 13'h1FFF;
		tc = 1'b0;
		pcnt = 6'h00;
		pfirst = 6'h00;
		hv = 1'b1;
		stat(16'hFC14, 16'hF800, 0);
		stat(16'hFC15, 16'hF800, 0);
		stat(16'hFC02, 16'hF900, 0);
		sum = 16'h0000;
		xact(16'hFC24, 16'hF800, {16'h0FFF, 16'h1234, 16'h0ABC, 16'hFFF8});
		stat(16'hFC02, 16'hF900, 0);
		xact(16'hFC22, 16'hF900, {16'h0000, sum});
		chk("load done", 16'h0001, 16'(done));
		$display("test entry_only done");
		end_of_test();
	end
endmodule : blrs_top_tb

`default_nettype wire
